/* File: verilog/bitop_pkg.sv */
// Shared constants and types for the bit-operation execute unit.
// Assumes a single core clock domain and a 12-bit instruction word.
package bitop_pkg;

    // ****************************************
    // Instruction word layout
    // ****************************************
    localparam int WORD_W = 12;           // Instruction width
    localparam int OPC_W = 4;             // Opcode field width
    localparam int BIT_W = 3;             // Bit select width
    localparam int REG_W = 5;             // File register select width
    localparam int DATA_W = 8;            // File register data width
    localparam int REG_COUNT = 32;        // File registers 0 to 31
    localparam int FREG_LSB = 0;          // Register field position
    localparam int BITSEL_LSB = 5;        // Bit field position
    localparam int OPC_LSB = 8;           // Opcode field position

    // ****************************************
    // Opcodes handled here
    // ****************************************
    localparam logic [3:0] OP_CLEAR_BIT = 4'h4;   // clear_bit_op
    localparam logic [3:0] OP_SET_BIT = 4'h5;     // set_bit_op
    localparam logic [3:0] OP_TEST_SKIP = 4'h6;   // test_skip_if_zero_op

    // ****************************************
    // Program counter and reset values
    // ****************************************
    localparam int PC_W = 11;                          // Program counter width
    localparam logic [10:0] PC_RESET = 11'h000;        // Counter after reset
    localparam logic [10:0] PC_STEP = 11'h001;         // One word per cycle
    localparam logic [7:0] DATA_RESET = 8'h00;         // Data register reset
    localparam logic [4:0] ADDR_RESET = 5'h00;         // Address register reset

    // Decoded instruction word
    typedef struct packed {
        logic [3:0] opcode;    // Operation
        logic [2:0] bitsel;    // Bit position 0 to 7
        logic [4:0] freg;      // File register 0 to 31
    } instr_type;

    // Committed register write
    typedef struct packed {
        logic valid;           // Write happened
        logic [4:0] addr;      // Target register
        logic [7:0] data;      // Value written
    } reg_write_type;

    // Execute slot state
    typedef enum logic [0:0] {
        EXEC_RUN,
        EXEC_SKIP
    } exec_state_type;

endpackage

/* File: verilog/file_regs.sv */
// File register storage, 32 words of 8 bits.
// Read data come from a register; a write to the address being read is forwarded.
`timescale 1ns/1ns
module file_regs
    import bitop_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [4:0] raddr,
    output logic [7:0] rdata_r
);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] mem [REG_COUNT];    // Register array, cleared by reset

    // Array write; reset clears every word so a first read-modify-write never sees unknowns
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < REG_COUNT; i++)
            begin
                mem[i] <= DATA_RESET;
            end
        end
        else if (ce && we)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read, write-first on address match
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdata_r <= DATA_RESET;
        end
        else if (ce)
        begin
            if (we && (waddr == raddr))
            begin
                rdata_r <= wdata;    // Forward to avoid stale read
            end
            else
            begin
                rdata_r <= mem[raddr];
            end
        end
    end

endmodule

/* File: verilog/bit_op_execute_unit.sv */
// Execute unit for bit clear, bit set and bit test with skip if zero.
// Assumes one fetched word arrives per enabled cycle, fetched one word ahead.
`timescale 1ns/1ns
module bit_op_execute_unit
    import bitop_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire bitop_pkg::instr_type fetch_word,
    output logic [10:0] pc_r,
    output logic nop_slot_r,
    output bitop_pkg::reg_write_type reg_write_r
);
    import bitop_pkg::*;

    // ****************************************
    // Pipeline and decode
    // ****************************************
    instr_type exec_r;                // Word in execute stage
    exec_state_type state_r;          // Execute slot state
    exec_state_type state_nxt;        // Next slot state
    logic [7:0] rd_data;              // Selected register value
    logic [7:0] mod_data;             // Value after bit update
    logic is_clear;                   // Clear-bit in execute
    logic is_set;                     // Set-bit in execute
    logic is_test;                    // Test-bit in execute
    logic test_bit;                   // Tested bit value
    logic wr_en;                      // Register write this cycle

    // Fetched word moves into execute
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            exec_r <= '0;
        end
        else if (ce)
        begin
            exec_r <= fetch_word;
        end
    end

    // Opcode decode, gated off in the inserted slot
    always_comb
    begin
        is_clear = (state_r == EXEC_RUN) && (exec_r.opcode == OP_CLEAR_BIT);
        is_set = (state_r == EXEC_RUN) && (exec_r.opcode == OP_SET_BIT);
        is_test = (state_r == EXEC_RUN) && (exec_r.opcode == OP_TEST_SKIP);
        test_bit = rd_data[exec_r.bitsel];
        wr_en = is_clear || is_set;
    end

    // ****************************************
    // Bit update, one lane per bit
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++)
        begin : g_lane
            // Selected lane takes the forced value
            assign mod_data[gi] = (exec_r.bitsel == 3'(gi)) ? is_set : rd_data[gi];
        end
    endgenerate

    // ****************************************
    // File registers
    // ****************************************
    // Read address from the incoming word so data are ready in execute
    file_regs u_regs (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .we(wr_en),
        .waddr(exec_r.freg),
        .wdata(mod_data),
        .raddr(fetch_word.freg),
        .rdata_r(rd_data)
    );

    // ****************************************
    // Skip control
    // ****************************************
    // Zero bit inserts one no-operation slot
    always_comb
    begin
        case (state_r)
            EXEC_RUN:
            begin
                state_nxt = (is_test && !test_bit) ? EXEC_SKIP : EXEC_RUN;
            end
            EXEC_SKIP:
            begin
                state_nxt = EXEC_RUN;
            end
            default:
            begin
                state_nxt = EXEC_RUN;
            end
        endcase
    end

    // Slot state register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r <= EXEC_RUN;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
        end
    end

    // Output flag for the inserted slot
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            nop_slot_r <= 1'b0;
        end
        else if (ce)
        begin
            nop_slot_r <= (state_nxt == EXEC_SKIP);
        end
    end

    // ****************************************
    // Program counter
    // ****************************************
    // Steps every enabled cycle, the no-op slot included, so the skipped word is passed
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pc_r <= PC_RESET;
        end
        else if (ce)
        begin
            pc_r <= pc_r + PC_STEP;
        end
    end

    // ****************************************
    // Committed write report
    // ****************************************
    // Echo of each register write, no status flag touched
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            reg_write_r <= '0;
        end
        else if (ce)
        begin
            reg_write_r.valid <= wr_en;
            reg_write_r.addr <= wr_en ? exec_r.freg : ADDR_RESET;
            reg_write_r.data <= wr_en ? mod_data : DATA_RESET;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_take_skip;
        ce && state_r == EXEC_RUN && exec_r.opcode == OP_TEST_SKIP && !test_bit;
    endsequence

    // Slot stands one enabled cycle; a low enable may stretch it
    sequence s_skip_slot;
        nop_slot_r ##1 (!$past(ce) || !nop_slot_r);
    endsequence

    property p_clear_bit;
        ce && is_clear |=> reg_write_r.valid && reg_write_r.data == ($past(rd_data) & ~(8'h01 << $past(exec_r.bitsel)));
    endproperty
    a_clear_bit: assert property (p_clear_bit) else $error("clear-bit result wrong");

    property p_set_bit;
        ce && is_set |=> reg_write_r.valid && reg_write_r.data == ($past(rd_data) | (8'h01 << $past(exec_r.bitsel)));
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("set-bit result wrong");

    property p_write_addr;
        ce && wr_en |=> reg_write_r.addr == $past(exec_r.freg);
    endproperty
    a_write_addr: assert property (p_write_addr) else $error("write went to wrong register");

    property p_test_no_write;
        ce && is_test |=> !reg_write_r.valid;
    endproperty
    a_test_no_write: assert property (p_test_no_write) else $error("test-bit wrote a register");

    property p_no_skip_on_one;
        ce && is_test && test_bit |=> !nop_slot_r && state_r == EXEC_RUN;
    endproperty
    a_no_skip_on_one: assert property (p_no_skip_on_one) else $error("skip taken on set bit");

    property p_skip_two_cycles;
        s_take_skip |=> s_skip_slot;
    endproperty
    a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip not exactly one slot");

    property p_slot_discards;
        ce && nop_slot_r |=> !reg_write_r.valid;
    endproperty
    a_slot_discards: assert property (p_slot_discards) else $error("discarded word executed");

    property p_pc_steps;
        ce |=> pc_r == $past(pc_r) + PC_STEP;
    endproperty
    a_pc_steps: assert property (p_pc_steps) else $error("counter did not step");

    property p_pc_past_skip;
        s_take_skip ##1 ce |=> pc_r == $past(pc_r, 2) + 11'h002;
    endproperty
    a_pc_past_skip: assert property (p_pc_past_skip) else $error("counter not past skipped word");

    property p_freeze;
        !ce |=> $stable(pc_r) && $stable(nop_slot_r) && $stable(reg_write_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");

endmodule

/* File: bench/bit_op_execute_unit_tb_top.sv */
// Self-checking bench for the bit-operation execute unit.
// Assumes bitop_pkg and the unit are compiled first.
`timescale 1ns/1ns
module bit_op_execute_unit_tb_top;
    import bitop_pkg::*;

    // ****************************************
    // Signals and bookkeeping
    // ****************************************
    typedef struct packed {
        logic chk;            // Compare this slot
        logic nop;            // Expected inserted no-op
        reg_write_type wr;    // Expected write echo
    } slot_type;

    logic clock;              // Core clock
    logic rst;                // Async reset
    logic ce;                 // Clock enable
    instr_type fetch_word;    // Word presented
    logic [10:0] pc_r;
    logic nop_slot_r;
    reg_write_type reg_write_r;
    int n_fail;
    int cmp_count;
    slot_type q[$];           // Two words in flight

    bit_op_execute_unit dut (.clock(clock), .rst(rst), .ce(ce), .fetch_word(fetch_word),
        .pc_r(pc_r), .nop_slot_r(nop_slot_r), .reg_write_r(reg_write_r));

    // 25 MHz clock
    initial
    begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Builds a word from opcode, bit and register
    function automatic logic [11:0] wd(input logic [3:0] op, input int b, input int f);
        return {op, b[2:0], f[4:0]};
    endfunction

    // Present one word; judge the slot of the word two edges back
    task automatic xfer(input logic [11:0] w, input logic chk, input logic nop, input logic v,
        input logic [7:0] d);
        slot_type s;
        logic [10:0] pv;
        s = slot_type'{chk, nop, reg_write_type'{v, v ? w[4:0] : 5'h00, v ? d : 8'h00}};
        q.push_back(s);
        pv = pc_r;
        @(posedge clock);
        fetch_word <= w;
        ce <= 1'h1;
        #1;
        check("pc_r", {5'h00, pc_r}, {5'h00, pv + 11'h001});
        s = q.pop_front();
        if (s.chk)
        begin
            check("nop_slot_r", {15'h0000, nop_slot_r}, {15'h0000, s.nop});
            check("reg_write_r", {2'h0, reg_write_r}, {2'h0, s.wr});
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    // Back-to-back clears and sets on one register
    task automatic t_bits(input int f);
        for (int i = 0; i < 8; i++)
            xfer(wd(OP_CLEAR_BIT, i, f), i == 7, 1'h0, 1'h1, 8'h00);
        xfer(wd(OP_SET_BIT, 0, f), 1'h1, 1'h0, 1'h1, 8'h01);
        xfer(wd(OP_SET_BIT, 1, f), 1'h1, 1'h0, 1'h1, 8'h03);
        xfer(wd(OP_SET_BIT, 2, f), 1'h1, 1'h0, 1'h1, 8'h07);
        xfer(wd(OP_SET_BIT, 6, f), 1'h1, 1'h0, 1'h1, 8'h47);
        xfer(wd(OP_SET_BIT, 7, f), 1'h1, 1'h0, 1'h1, 8'hC7);
        xfer(wd(OP_CLEAR_BIT, 7, f), 1'h1, 1'h0, 1'h1, 8'h47);
        $display("test t_bits reg %0d done", f);
    endtask

    // Test every bit of 0x47, then a real discard
    task automatic t_skip(input int f);
        logic [7:0] v;
        v = 8'h47;
        for (int b = 0; b < 8; b++)
        begin
            xfer(wd(OP_TEST_SKIP, b, f), 1'h1, ~v[b], 1'h0, 8'h00);
            xfer(12'h000, 1'h1, 1'h0, 1'h0, 8'h00);
        end
        xfer(wd(OP_TEST_SKIP, 7, f), 1'h1, 1'h1, 1'h0, 8'h00);
        xfer(wd(OP_SET_BIT, 3, f), 1'h1, 1'h0, 1'h0, 8'h00);
        xfer(wd(OP_SET_BIT, 4, f), 1'h1, 1'h0, 1'h1, 8'h57);
        xfer(wd(OP_TEST_SKIP, 4, f), 1'h1, 1'h0, 1'h0, 8'h00);
        xfer(wd(OP_SET_BIT, 5, f), 1'h1, 1'h0, 1'h1, 8'h77);
        $display("test t_skip done");
    endtask

    // Opcodes outside this unit do nothing
    task automatic t_other(input int f);
        for (int op = 0; op < 16; op++)
            if (op < 4 || op > 6)
                xfer(wd(op[3:0], 0, f), 1'h1, 1'h0, 1'h0, 8'h00);
        xfer(wd(OP_CLEAR_BIT, 0, f), 1'h1, 1'h0, 1'h1, 8'h76);
        xfer(12'h000, 1'h1, 1'h0, 1'h0, 8'h00);
        xfer(12'h000, 1'h1, 1'h0, 1'h0, 8'h00);
        $display("test t_other done");
    endtask

    // Enable low freezes the counter
    task automatic t_hold();
        logic [10:0] pv;
        @(posedge clock);
        ce <= 1'h0;
        #1;
        pv = pc_r;
        q.delete(0);
        q.push_back('0);
        repeat (4) @(posedge clock);
        #1;
        check("pc_r hold", {5'h00, pc_r}, {5'h00, pv});
        @(posedge clock);
        ce <= 1'h1;
        xfer(12'h000, 1'h1, 1'h0, 1'h0, 8'h00);
        $display("test t_hold done");
    endtask

    // ****************************************
    // Verdict, main sequence and watchdog
    // ****************************************
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        rst = 1'h1;
        ce = 1'h1;
        fetch_word = '0;
        n_fail = 0;
        cmp_count = 0;
        q.push_back('0);
        q.push_back('0);
        repeat (16) @(posedge clock);
        rst <= 1'h0;
        #1;
        t_bits(31);
        t_bits(0);
        t_skip(31);
        t_other(31);
        t_hold();
        wrap_up();
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        n_fail++;
        $display("[ERR] watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule
